/* jse_consts.svh */
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 100 MHz core clock, byte-wide register port
// Notes: included by the register bank and its interrupt unit
`ifndef JSE_CONSTS_SVH
`define JSE_CONSTS_SVH

// register indices
`define JSE_IDX_CTRL 8'h0F
`define JSE_IDX_X 8'h10
`define JSE_IDX_Y 8'h11
`define JSE_IDX_XP 8'h12
`define JSE_IDX_XN 8'h13
`define JSE_IDX_YP 8'h14
`define JSE_IDX_YN 8'h15
`define JSE_IDX_SCALE 8'h2D

// control register fields
`define JSE_CTRL_BUSY_BIT 0
`define JSE_CTRL_SOFT_BIT 1
`define JSE_CTRL_WAKE_BIT 2
`define JSE_CTRL_IDLE_BIT 7
`define JSE_CTRL_BIT0_MASK 8'hFE

// reset values
`define JSE_RST_CTRL 8'hF0
`define JSE_RST_LIMIT 8'h00
`define JSE_RST_SCALE 8'h00
`define JSE_RST_COORD 8'h00
`define JSE_RDATA_NONE 8'h00

// timing
`define JSE_CLK_PERIOD_NS 10
`define JSE_TB_BASE_NS 20000000
`define JSE_TB_BASE_CYCLES (`JSE_TB_BASE_NS / `JSE_CLK_PERIOD_NS)
`define JSE_LOAD_CYCLES 4'h4

`endif

/* jse_pkg.sv */
// Purpose: types shared by the joystick encoder register bank
// Assumes: constants live in jse_consts.svh
// Notes: no imports, every use is written jse_pkg::name
package jse_pkg;

  typedef enum logic [1:0] {
    ST_LOAD,
    ST_START,
    ST_MEAS,
    ST_WAIT
  } jse_state_t;

  typedef struct packed {
    logic idle;
    logic [2:0] timebase;
    logic int_aux;
    logic int_wake;
    logic soft_rst;
    logic busy;
  } jse_ctrl_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] idx;
    logic [7:0] wdata;
  } jse_regreq_t;

  typedef struct packed {
    logic [7:0] xp;
    logic [7:0] xn;
    logic [7:0] yp;
    logic [7:0] yn;
  } jse_limits_t;

endpackage : jse_pkg

/* jse_irq_unit.sv */
// Purpose: drives the active-low interrupt pin of the encoder
// Assumes: new_pair and y_read are one-cycle pulses on the core clock
// Notes: wake mode follows the threshold window, else ready/clear flag
`timescale 1ns/1ps
`include "jse_consts.svh"

module jse_irq_unit (
  input wire logic clk,
  input wire logic rst,
  input wire logic wake_mode,
  input wire logic new_pair,
  input wire logic y_read,
  input wire logic [7:0] x,
  input wire logic [7:0] y,
  input wire jse_pkg::jse_limits_t limits,
  output logic irq_low_ff,
  output logic irq_oe_ff
);

  logic outside;
  logic nxt_irq_low;

  // signed two's-complement window test
  assign outside = ($signed(x) > $signed(limits.xp)) ||
                   ($signed(x) < $signed(limits.xn)) ||
                   ($signed(y) > $signed(limits.yp)) ||
                   ($signed(y) < $signed(limits.yn));

  always_comb
  begin
    nxt_irq_low = irq_low_ff;
    if (wake_mode)
    begin
      if (new_pair)
        nxt_irq_low = ~outside;
    end
    else if (new_pair)
      nxt_irq_low = 1'b0;
    else if (y_read)
      nxt_irq_low = 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      irq_low_ff <= 1'b1;
      irq_oe_ff <= 1'b0;
    end
    else
    begin
      irq_low_ff <= nxt_irq_low;
      irq_oe_ff <= ~nxt_irq_low;
    end
  end

  property p_ready_set;
    @(posedge clk) disable iff (rst)
    (!wake_mode && new_pair) |=> (!irq_low_ff && irq_oe_ff);
  endproperty
  a_ready_set: assert property (p_ready_set)
    else $error("fresh pair did not pull interrupt low");

  property p_yread_clear;
    @(posedge clk) disable iff (rst)
    (!wake_mode && y_read && !new_pair) |=> irq_low_ff;
  endproperty
  a_yread_clear: assert property (p_yread_clear)
    else $error("y read did not release interrupt");

  property p_wake_window;
    @(posedge clk) disable iff (rst)
    (wake_mode && new_pair) |=> (irq_low_ff == !$past(outside));
  endproperty
  a_wake_window: assert property (p_wake_window)
    else $error("wake interrupt does not follow threshold window");

endmodule : jse_irq_unit

/* jse_regs.sv */
// Purpose: register bank, start-up sequencing and interrupt of the
//   magnetic joystick encoder
// Assumes: register port driven by the serial slave on CORE_CLK;
//   measurement engine answers MEAS_START with MEAS_DONE
// Notes: RESET is the internal power-on reset, asserted once only
//
// Behaviour
// - power-on reset loads all register defaults once, then stays inactive
// - supply dips do not re-run reset; only an explicit reset restores
// - after reset control reads F0h once bit 0 is masked off
// - control 00h selects low power, 20ms timebase, ready interrupt
// - in ready mode reading the Y register clears a pending interrupt, pin goes high
// - in ready mode each fresh X/Y pair pulls interrupt low
// - X at 10h and Y at 11h as signed 8-bit values
// - four writable wake thresholds at indices 12h to 15h
// - wake mode: interrupt high inside window, low once a limit passed
`timescale 1ns/1ps
`include "jse_consts.svh"

module jse_regs #(
  parameter logic [31:0] TB_BASE_CYCLES = `JSE_TB_BASE_CYCLES
) (
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic EXT_RESET_LOW,
  input wire logic [7:0] REG_IDX,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] MEAS_X,
  input wire logic [7:0] MEAS_Y,
  input wire logic MEAS_DONE,
  output logic [7:0] REG_RDATA,
  output logic MEAS_START,
  output logic [7:0] SCALE_FACTOR,
  output logic IRQ_LOW_OUT,
  output logic IRQ_LOW_OE
);

  function automatic logic hit(input logic [7:0] idx,
                               input logic [7:0] off);
    hit = (idx == off);
  endfunction : hit

  jse_pkg::jse_regreq_t req;
  jse_pkg::jse_state_t state_ff;
  jse_pkg::jse_state_t nxt_state;
  jse_pkg::jse_ctrl_t ctrl_ff;
  jse_pkg::jse_limits_t limits_ff;
  logic ext_s1_ff;
  logic ext_s2_ff;
  logic [3:0] load_cnt_ff;
  logic [31:0] tb_cnt_ff;
  logic [31:0] tb_limit;
  logic tb_expired;
  logic [7:0] x_ff;
  logic [7:0] y_ff;
  logic [7:0] scale_ff;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic start_ff;
  logic new_pair_ff;
  logic loading;
  logic soft_rst;
  logic reload;
  logic y_read;
  logic irq_rst;

  assign req = '{wr: REG_WR, rd: REG_RD, idx: REG_IDX, wdata: REG_WDATA};
  assign loading = (state_ff == jse_pkg::ST_LOAD);
  assign soft_rst = req.wr && !loading && hit(req.idx, `JSE_IDX_CTRL) &&
                    req.wdata[`JSE_CTRL_SOFT_BIT];
  // external pin or soft bit restore defaults; supply dips do not
  assign reload = !ext_s2_ff || soft_rst;
  assign y_read = req.rd && !loading && hit(req.idx, `JSE_IDX_Y);
  assign irq_rst = RESET || reload || loading;

  // external reset pin passes two flip-flops
  always_ff @(posedge CORE_CLK)
  begin
    if (RESET)
    begin
      ext_s1_ff <= 1'b1;
      ext_s2_ff <= 1'b1;
    end
    else
    begin
      ext_s1_ff <= EXT_RESET_LOW;
      ext_s2_ff <= ext_s1_ff;
    end
  end

  // start-up, measurement and wait sequencing
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      jse_pkg::ST_LOAD:
        if (load_cnt_ff == `JSE_LOAD_CYCLES - 4'h1)
          nxt_state = jse_pkg::ST_START;
      jse_pkg::ST_START:
        nxt_state = jse_pkg::ST_MEAS;
      jse_pkg::ST_MEAS:
        if (MEAS_DONE)
          nxt_state = jse_pkg::ST_WAIT;
      jse_pkg::ST_WAIT:
        if (tb_expired)
          nxt_state = jse_pkg::ST_START;
      default:
        nxt_state = jse_pkg::ST_LOAD;
    endcase
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RESET || reload)
    begin
      state_ff <= jse_pkg::ST_LOAD;
      load_cnt_ff <= 4'h0;
    end
    else
    begin
      state_ff <= nxt_state;
      load_cnt_ff <= loading ? load_cnt_ff + 4'h1 : 4'h0;
    end
  end

  // low-power timebase: base period doubled per timebase step
  assign tb_limit = TB_BASE_CYCLES << ctrl_ff.timebase;
  assign tb_expired = (state_ff == jse_pkg::ST_WAIT) && !ctrl_ff.idle &&
                      (tb_cnt_ff >= tb_limit - 32'h1);

  always_ff @(posedge CORE_CLK)
  begin
    if (RESET || reload || state_ff != jse_pkg::ST_WAIT || ctrl_ff.idle)
      tb_cnt_ff <= 32'h0;
    else
      tb_cnt_ff <= tb_cnt_ff + 32'h1;
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RESET || reload)
      start_ff <= 1'b0;
    else
      start_ff <= (state_ff == jse_pkg::ST_START);
  end

  // capture each finished conversion
  always_ff @(posedge CORE_CLK)
  begin
    if (RESET || reload)
    begin
      x_ff <= `JSE_RST_COORD;
      y_ff <= `JSE_RST_COORD;
      new_pair_ff <= 1'b0;
    end
    else
    begin
      new_pair_ff <= (state_ff == jse_pkg::ST_MEAS) && MEAS_DONE;
      if ((state_ff == jse_pkg::ST_MEAS) && MEAS_DONE)
      begin
        x_ff <= MEAS_X;
        y_ff <= MEAS_Y;
      end
    end
  end

  // writable registers, one byte at one index per access
  always_ff @(posedge CORE_CLK)
  begin
    if (RESET || reload)
    begin
      ctrl_ff <= `JSE_RST_CTRL;
      limits_ff <= {4{`JSE_RST_LIMIT}};
      scale_ff <= `JSE_RST_SCALE;
    end
    else if (req.wr && !loading)
    begin
      if (hit(req.idx, `JSE_IDX_CTRL))
        ctrl_ff <= req.wdata & `JSE_CTRL_BIT0_MASK &
                   ~(8'h01 << `JSE_CTRL_SOFT_BIT);
      if (hit(req.idx, `JSE_IDX_XP))
        limits_ff.xp <= req.wdata;
      if (hit(req.idx, `JSE_IDX_XN))
        limits_ff.xn <= req.wdata;
      if (hit(req.idx, `JSE_IDX_YP))
        limits_ff.yp <= req.wdata;
      if (hit(req.idx, `JSE_IDX_YN))
        limits_ff.yn <= req.wdata;
      if (hit(req.idx, `JSE_IDX_SCALE))
        scale_ff <= req.wdata;
    end
  end

  // read data; control reads zero until defaults are loaded
  always_comb
  begin
    nxt_rdata = `JSE_RDATA_NONE;
    case (req.idx)
      `JSE_IDX_CTRL:
        if (!loading)
          nxt_rdata = {ctrl_ff[7:1],
                       state_ff != jse_pkg::ST_WAIT};
      `JSE_IDX_X: nxt_rdata = x_ff;
      `JSE_IDX_Y: nxt_rdata = y_ff;
      `JSE_IDX_XP: nxt_rdata = limits_ff.xp;
      `JSE_IDX_XN: nxt_rdata = limits_ff.xn;
      `JSE_IDX_YP: nxt_rdata = limits_ff.yp;
      `JSE_IDX_YN: nxt_rdata = limits_ff.yn;
      `JSE_IDX_SCALE: nxt_rdata = scale_ff;
      default: nxt_rdata = `JSE_RDATA_NONE;
    endcase
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RESET)
      rdata_ff <= `JSE_RDATA_NONE;
    else if (req.rd)
      rdata_ff <= nxt_rdata;
  end

  jse_irq_unit u_irq (
    .clk(CORE_CLK),
    .rst(irq_rst),
    .wake_mode(ctrl_ff.int_wake),
    .new_pair(new_pair_ff),
    .y_read(y_read),
    .x(x_ff),
    .y(y_ff),
    .limits(limits_ff),
    .irq_low_ff(IRQ_LOW_OUT),
    .irq_oe_ff(IRQ_LOW_OE)
  );

  assign REG_RDATA = rdata_ff;
  assign MEAS_START = start_ff;
  assign SCALE_FACTOR = scale_ff;

  property p_load_to_f0;
    @(posedge CORE_CLK) disable iff (RESET)
    ($past(loading) && !loading && !$past(reload)) |->
      ((ctrl_ff & `JSE_CTRL_BIT0_MASK) == `JSE_RST_CTRL);
  endproperty
  a_load_to_f0: assert property (p_load_to_f0)
    else $error("control not at default when loading ends");

  property p_poll_masked;
    @(posedge CORE_CLK) disable iff (RESET)
    (req.rd && hit(req.idx, `JSE_IDX_CTRL) && loading) |=>
      (REG_RDATA == `JSE_RDATA_NONE);
  endproperty
  a_poll_masked: assert property (p_poll_masked)
    else $error("control read nonzero before defaults loaded");

  property p_ext_reset;
    @(posedge CORE_CLK) disable iff (RESET)
    $fell(ext_s2_ff) |=> loading [*4];
  endproperty
  a_ext_reset: assert property (p_ext_reset)
    else $error("external reset did not hold loading four cycles");

  property p_ctrl_zero;
    @(posedge CORE_CLK) disable iff (RESET)
    (req.wr && !loading && !reload && hit(req.idx, `JSE_IDX_CTRL) &&
     req.wdata == 8'h00) |=>
      (!ctrl_ff.idle && ctrl_ff.timebase == 3'h0 && !ctrl_ff.int_wake &&
       tb_limit == TB_BASE_CYCLES);
  endproperty
  a_ctrl_zero: assert property (p_ctrl_zero)
    else $error("writing 00h did not select 20ms low power");

  property p_tb_start;
    @(posedge CORE_CLK) disable iff (RESET)
    (tb_expired && !reload) ##1 !reload |=> MEAS_START;
  endproperty
  a_tb_start: assert property (p_tb_start)
    else $error("timebase expiry did not start a measurement");

  property p_read_x;
    @(posedge CORE_CLK) disable iff (RESET)
    (req.rd && hit(req.idx, `JSE_IDX_X)) |=> (REG_RDATA == $past(x_ff));
  endproperty
  a_read_x: assert property (p_read_x)
    else $error("x register read returned wrong value");

  property p_write_xn;
    @(posedge CORE_CLK) disable iff (RESET)
    (req.wr && !loading && !reload && hit(req.idx, `JSE_IDX_XN)) |=>
      (limits_ff.xn == $past(req.wdata) &&
       limits_ff.xp == $past(limits_ff.xp));
  endproperty
  a_write_xn: assert property (p_write_xn)
    else $error("negative x threshold write not independent");

endmodule : jse_regs

/* jse_meas_model.sv */
// Purpose: measurement engine stand-in that answers conversion requests
// Assumes: one conversion at a time, answer delay chosen by the bench
// Notes: result lines toggle outside the done pulse, never hold old data
`timescale 1ns/1ps

module jse_meas_model (
  input wire logic clk,
  input wire logic start,
  input wire logic [7:0] x_val,
  input wire logic [7:0] y_val,
  input wire logic [3:0] delay,
  output logic done,
  output logic [7:0] meas_x,
  output logic [7:0] meas_y
);
  logic [3:0] cnt_ff = 4'h0;
  logic busy_ff = 1'b0;

  initial
  begin
    done = 1'b0;
    meas_x = 8'h00;
    meas_y = 8'hFF;
  end

  always @(posedge clk)
  begin
    done <= 1'b0;
    meas_x <= ~meas_x;
    meas_y <= ~meas_y;
    if (start)
    begin
      busy_ff <= 1'b1;
      cnt_ff <= delay;
    end
    else if (busy_ff && cnt_ff == 4'h0)
    begin
      // x and y are handed over together
      busy_ff <= 1'b0;
      done <= 1'b1;
      meas_x <= x_val;
      meas_y <= y_val;
    end
    else if (busy_ff)
      cnt_ff <= cnt_ff - 4'h1;
  end
endmodule : jse_meas_model

/* jse_regs_tb.sv */
// Purpose: self-checking bench of the encoder register bank
// Assumes: short timebase of 20 cycles, seed 1368
// Notes: host side is played by the register tasks below
`timescale 1ns/1ps
`include "jse_consts.svh"

module jse_regs_tb;
  logic CORE_CLK = 1'b0;
  logic RESET = 1'b1;
  logic EXT_RESET_LOW = 1'b1;
  logic [7:0] REG_IDX = 8'h00;
  logic [7:0] REG_WDATA = 8'h00;
  logic REG_WR = 1'b0;
  logic REG_RD = 1'b0;
  logic [7:0] MEAS_X, MEAS_Y, REG_RDATA, SCALE_FACTOR;
  logic MEAS_DONE, MEAS_START, IRQ_LOW_OUT, IRQ_LOW_OE;
  logic [7:0] xv = 8'h00;
  logic [7:0] yv = 8'h00;
  logic [3:0] dly = 4'h1;
  logic [7:0] rd;
  logic [7:0] lim [4];
  logic [7:0] wx [6] = '{8'h0A, 8'h0B, 8'hF6, 8'hF5, 8'h00, 8'h03};
  logic [7:0] wy [6] = '{8'h00, 8'h00, 8'hF6, 8'h00, 8'h0B, 8'hF5};
  int sx = 0;
  int sy = 0;
  logic [7:0] offx;
  logic [7:0] offy;
  int errors = 0;
  int checked = 0;
  int cycles = 0;

  always #5 CORE_CLK = ~CORE_CLK;

  jse_regs #(.TB_BASE_CYCLES(32'h14)) u_dut (
    .CORE_CLK(CORE_CLK), .RESET(RESET), .EXT_RESET_LOW(EXT_RESET_LOW),
    .REG_IDX(REG_IDX), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .MEAS_X(MEAS_X), .MEAS_Y(MEAS_Y),
    .MEAS_DONE(MEAS_DONE), .REG_RDATA(REG_RDATA),
    .MEAS_START(MEAS_START), .SCALE_FACTOR(SCALE_FACTOR),
    .IRQ_LOW_OUT(IRQ_LOW_OUT), .IRQ_LOW_OE(IRQ_LOW_OE)
  );

  jse_meas_model u_meas (
    .clk(CORE_CLK), .start(MEAS_START), .x_val(xv), .y_val(yv),
    .delay(dly), .done(MEAS_DONE), .meas_x(MEAS_X), .meas_y(MEAS_Y)
  );

  task automatic results();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : results

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] idx, input logic [7:0] val);
    @(posedge CORE_CLK);
    REG_WR <= 1'b1;
    REG_IDX <= idx;
    REG_WDATA <= val;
    @(posedge CORE_CLK);
    REG_WR <= 1'b0;
  endtask : wr

  // one byte at one index per access
  task automatic rdreg(input logic [7:0] idx);
    @(posedge CORE_CLK);
    REG_RD <= 1'b1;
    REG_IDX <= idx;
    @(posedge CORE_CLK);
    REG_RD <= 1'b0;
    @(posedge CORE_CLK);
    #1;
    rd = REG_RDATA;
  endtask : rdreg

  task automatic poll();
    for (int i = 0; i < 40; i++)
    begin
      rdreg(`JSE_IDX_CTRL);
      if ((rd & `JSE_CTRL_BIT0_MASK) === `JSE_RST_CTRL)
        break;
    end
    check(rd & `JSE_CTRL_BIT0_MASK, `JSE_RST_CTRL);
  endtask : poll

  // wait for the next result, then let the pin update land
  task automatic wait_pair();
    int n;
    n = 0;
    while (MEAS_DONE !== 1'b1 && n < 200)
    begin
      @(posedge CORE_CLK);
      #1;
      n++;
    end
    check({7'h00, n < 200}, 8'h01);
    repeat (2) @(posedge CORE_CLK);
    #1;
  endtask : wait_pair

  task automatic set_xy(input logic [7:0] x, input logic [7:0] y);
    @(posedge CORE_CLK);
    xv <= x;
    yv <= y;
    dly <= 4'($urandom_range(7));
  endtask : set_xy

  function automatic logic inside_win(input logic [7:0] x,
                                      input logic [7:0] y);
    return $signed(x) <= $signed(lim[0]) && $signed(x) >= $signed(lim[1]) &&
      $signed(y) <= $signed(lim[2]) && $signed(y) >= $signed(lim[3]);
  endfunction : inside_win

  always @(posedge CORE_CLK)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      results();
    end
  end

  initial
  begin
    void'($urandom(1368));
    xv = 8'($urandom);
    repeat (5) @(posedge CORE_CLK);
    RESET <= 1'b0;
    #1;
    check(IRQ_LOW_OUT, 8'h01);
    check(IRQ_LOW_OE, 8'h00);
    check(SCALE_FACTOR, `JSE_RST_SCALE);
    poll();
    $display("test reset done");
    wr(`JSE_IDX_SCALE, 8'h06);
    rdreg(`JSE_IDX_SCALE);
    check(rd, 8'h06);
    check(SCALE_FACTOR, 8'h06);
    $display("test scale done");
    for (int i = 0; i < 4; i++)
    begin
      lim[i] = 8'($urandom);
      wr(`JSE_IDX_XP + 8'(i), lim[i]);
    end
    for (int i = 0; i < 4; i++)
    begin
      rdreg(`JSE_IDX_XP + 8'(i));
      check(rd, lim[i]);
    end
    rdreg(8'h20);
    check(rd, `JSE_RDATA_NONE);
    wr(`JSE_IDX_X, ~xv);
    rdreg(`JSE_IDX_X);
    check(rd, xv);
    $display("test limits done");
    wr(`JSE_IDX_CTRL, 8'h00);
    rdreg(`JSE_IDX_Y);
    // first six pairs full range, then sixteen near-centre calibration pairs
    for (int k = 0; k < 22; k++)
    begin
      if (k < 6)
        set_xy(8'($urandom), 8'($urandom));
      else
        set_xy(8'($urandom_range(9)) - 8'h04,
               8'($urandom_range(9)) - 8'h04);
      wait_pair();
      check(IRQ_LOW_OUT, 8'h00);
      check(IRQ_LOW_OE, 8'h01);
      rdreg(`JSE_IDX_X);
      check(rd, xv);
      if (k >= 6)
        sx += int'($signed(rd));
      rdreg(`JSE_IDX_Y);
      check(rd, yv);
      if (k >= 6)
        sy += int'($signed(rd));
      check(IRQ_LOW_OUT, 8'h01);
      check(IRQ_LOW_OE, 8'h00);
    end
    offx = 8'(-(sx >>> 4));
    offy = 8'(-(sy >>> 4));
    $display("test ready mode done");
    lim[0] = 8'h0A - offx;
    lim[1] = 8'hF6 - offx;
    lim[2] = 8'h0A - offy;
    lim[3] = 8'hF6 - offy;
    for (int i = 0; i < 4; i++)
      wr(`JSE_IDX_XP + 8'(i), lim[i]);
    wr(`JSE_IDX_CTRL, 8'h04);
    for (int k = 0; k < 6; k++)
    begin
      set_xy(wx[k], wy[k]);
      wait_pair();
      check(IRQ_LOW_OUT, {7'h00, inside_win(wx[k], wy[k])});
      rdreg(`JSE_IDX_Y);
      check(IRQ_LOW_OUT, {7'h00, inside_win(wx[k], wy[k])});
    end
    $display("test wake mode done");
    wr(`JSE_IDX_CTRL, 8'h02);
    poll();
    check(SCALE_FACTOR, `JSE_RST_SCALE);
    rdreg(`JSE_IDX_XP);
    check(rd, `JSE_RST_LIMIT);
    $display("test soft reset done");
    wr(`JSE_IDX_SCALE, 8'h06);
    @(posedge CORE_CLK);
    EXT_RESET_LOW <= 1'b0;
    repeat (12) @(posedge CORE_CLK);
    EXT_RESET_LOW <= 1'b1;
    poll();
    check(SCALE_FACTOR, `JSE_RST_SCALE);
    $display("test external reset done");
    results();
  end
endmodule : jse_regs_tb
